// [rtl/smi_regs.vh]
// Register map, field positions and timing constants of the supply monitor
`ifndef SMI_REGS_VH
`define SMI_REGS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define SMI_CTRL_ADDR 8'hdf
`define SMI_CTRL_RESET 8'hde

// ****************************************************************
// Field positions
// ****************************************************************
`define SMI_BIT_DIG_CMP 7
`define SMI_BIT_ANA_CMP 6
`define SMI_BIT_LOW_FLAG 5
`define SMI_BIT_DTRIP_HI 4
`define SMI_BIT_DTRIP_LO 3
`define SMI_BIT_ATRIP_HI 2
`define SMI_BIT_ATRIP_LO 1
`define SMI_BIT_ENABLE 0

// ****************************************************************
// Trip point codes, millivolts
// ****************************************************************
`define SMI_TRIP_SEL_463 2'h0
`define SMI_TRIP_SEL_308 2'h1
`define SMI_TRIP_SEL_293 2'h2
`define SMI_TRIP_SEL_263 2'h3
`define SMI_TRIP_MV_463 13'h1216
`define SMI_TRIP_MV_308 13'h0c08
`define SMI_TRIP_MV_293 13'h0b72
`define SMI_TRIP_MV_263 13'h0a46

// ****************************************************************
// Timing
// ****************************************************************
`define SMI_HOLDOFF_MS 250
`define SMI_CLK_MHZ 100
`define SMI_HOLDOFF_CYCLES (`SMI_HOLDOFF_MS * 1000 * `SMI_CLK_MHZ)
`define SMI_GLITCH_CYCLES 4

`endif

// [rtl/smi_supply_monitor.v]
// Control and status logic of the analog and digital supply monitor
`timescale 1ns/100ps

`include "smi_regs.vh"

module smi_supply_monitor #(
    parameter HOLDOFF_CYCLES = `SMI_HOLDOFF_CYCLES,
    parameter GLITCH_CYCLES = `SMI_GLITCH_CYCLES
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Special function register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    // Comparators, raw
    input wire digital_supply_above_trip,
    input wire analog_supply_above_trip,
    // Interrupt enable from the secondary enable and priority register
    input wire secondary_irq_enable_priority,
    // Comparator control
    output reg monitor_enable,
    output reg [1:0] digital_trip_sel,
    output reg [1:0] analog_trip_sel,
    output reg [12:0] digital_trip_mv,
    output reg [12:0] analog_trip_mv,
    // Status
    output reg supply_low_flag,
    output reg supply_low_irq
);

// ****************************************************************
// Helpers
// ****************************************************************
function [12:0] trip_mv;
    input [1:0] sel;
    begin
        case (sel)
            `SMI_TRIP_SEL_463: trip_mv = `SMI_TRIP_MV_463;
            `SMI_TRIP_SEL_308: trip_mv = `SMI_TRIP_MV_308;
            `SMI_TRIP_SEL_293: trip_mv = `SMI_TRIP_MV_293;
            default: trip_mv = `SMI_TRIP_MV_263;
        endcase
    end
endfunction

localparam ST_IDLE = 2'h0;
localparam ST_LOW = 2'h1;
localparam ST_HOLD = 2'h2;

// ****************************************************************
// Reset image
// ****************************************************************
// Power-on value of the control register, split into its fields
wire [7:0] ctrl_reset_image;
wire rst_enable;
wire [1:0] rst_dtrip;
wire [1:0] rst_atrip;
wire rst_flag;
assign ctrl_reset_image = `SMI_CTRL_RESET;
assign rst_enable = ctrl_reset_image[`SMI_BIT_ENABLE];
assign rst_dtrip = {ctrl_reset_image[`SMI_BIT_DTRIP_HI],
                    ctrl_reset_image[`SMI_BIT_DTRIP_LO]};
assign rst_atrip = {ctrl_reset_image[`SMI_BIT_ATRIP_HI],
                    ctrl_reset_image[`SMI_BIT_ATRIP_LO]};
assign rst_flag = ctrl_reset_image[`SMI_BIT_LOW_FLAG];

// Last count of the glitch filter and of the hold-off counter
wire [7:0] glitch_last;
wire [31:0] hold_last;
assign glitch_last = GLITCH_CYCLES - 1;
assign hold_last = HOLDOFF_CYCLES - 1;

// ****************************************************************
// Glitch filter
// ****************************************************************
// Output changes only after input held steady for GLITCH_CYCLES
wire [1:0] raw_cmp;
wire [1:0] cmp_filt;
assign raw_cmp = {digital_supply_above_trip, analog_supply_above_trip};

genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
        reg [7:0] cnt_reg;
        reg filt_reg;
        always @(posedge clk_sys) begin
            if (rst) begin
                cnt_reg <= 8'h00;
                filt_reg <= 1'b1;
            end else if (raw_cmp[gi] == filt_reg) begin
                cnt_reg <= 8'h00;
            end else if (cnt_reg >= glitch_last) begin
                cnt_reg <= 8'h00;
                filt_reg <= raw_cmp[gi];
            end else begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
        assign cmp_filt[gi] = filt_reg;
    end
endgenerate

wire dig_ok;
wire ana_ok;
wire any_low;
wire both_ok;
assign dig_ok = cmp_filt[1];
assign ana_ok = cmp_filt[0];
// Disabled monitor reports no fault
assign any_low = monitor_enable & (~dig_ok | ~ana_ok);
assign both_ok = ~any_low;

// ****************************************************************
// Register write
// ****************************************************************
wire ctrl_wr;
assign ctrl_wr = sfr_wr & (sfr_addr == `SMI_CTRL_ADDR);

// Enable bit
always @(posedge clk_sys) begin
    if (rst) begin
        monitor_enable <= rst_enable;
    end else if (ctrl_wr) begin
        monitor_enable <= sfr_wdata[`SMI_BIT_ENABLE];
    end
end

// Digital trip select
always @(posedge clk_sys) begin
    if (rst) begin
        digital_trip_sel <= rst_dtrip;
    end else if (ctrl_wr) begin
        digital_trip_sel <= {sfr_wdata[`SMI_BIT_DTRIP_HI],
                             sfr_wdata[`SMI_BIT_DTRIP_LO]};
    end
end

// Analog trip select
always @(posedge clk_sys) begin
    if (rst) begin
        analog_trip_sel <= rst_atrip;
    end else if (ctrl_wr) begin
        analog_trip_sel <= {sfr_wdata[`SMI_BIT_ATRIP_HI],
                            sfr_wdata[`SMI_BIT_ATRIP_LO]};
    end
end

// Threshold levels lag the select by one cycle
always @(posedge clk_sys) begin
    if (rst) begin
        digital_trip_mv <= `SMI_TRIP_MV_463;
    end else begin
        digital_trip_mv <= trip_mv(digital_trip_sel);
    end
end

always @(posedge clk_sys) begin
    if (rst) begin
        analog_trip_mv <= `SMI_TRIP_MV_463;
    end else begin
        analog_trip_mv <= trip_mv(analog_trip_sel);
    end
end

// ****************************************************************
// Flag and hold-off
// ****************************************************************
reg [1:0] state_reg;
reg [1:0] state_next;
reg [31:0] hold_cnt_reg;
reg [31:0] hold_cnt_next;
reg flag_next;
wire sw_clear;
wire sw_set;
wire hold_done;
assign sw_clear = ctrl_wr & ~sfr_wdata[`SMI_BIT_LOW_FLAG];
assign sw_set = ctrl_wr & sfr_wdata[`SMI_BIT_LOW_FLAG];
assign hold_done = hold_cnt_reg >= hold_last;

always @* begin
    state_next = state_reg;
    hold_cnt_next = 32'h0;
    flag_next = supply_low_flag;
    case (state_reg)
        ST_IDLE: begin
            if (any_low) begin
                flag_next = 1'b1;
                state_next = ST_LOW;
            end else if (sw_set) begin
                flag_next = 1'b1;
            end else if (sw_clear) begin
                flag_next = 1'b0;
            end
        end
        ST_LOW: begin
            // Software clear has no effect here
            flag_next = 1'b1;
            if (both_ok) begin
                state_next = ST_HOLD;
            end
        end
        ST_HOLD: begin
            if (any_low) begin
                flag_next = 1'b1;
                state_next = ST_LOW;
            end else if (hold_done) begin
                flag_next = 1'b0;
                state_next = ST_IDLE;
            end else begin
                hold_cnt_next = hold_cnt_reg + 32'h1;
                if (sw_clear) begin
                    flag_next = 1'b0;
                end else if (sw_set) begin
                    flag_next = 1'b1;
                end
            end
        end
        default: begin
            state_next = ST_IDLE;
        end
    endcase
end

always @(posedge clk_sys) begin
    if (rst) begin
        state_reg <= ST_IDLE;
        hold_cnt_reg <= 32'h0;
        supply_low_flag <= rst_flag;
        supply_low_irq <= 1'b0;
    end else begin
        state_reg <= state_next;
        hold_cnt_reg <= hold_cnt_next;
        supply_low_flag <= flag_next;
        supply_low_irq <= flag_next & secondary_irq_enable_priority;
    end
end

// ****************************************************************
// Read back
// ****************************************************************
// Status bits show the raw comparators, not the filtered ones
wire [7:0] ctrl_image;
assign ctrl_image[`SMI_BIT_DIG_CMP] = digital_supply_above_trip;
assign ctrl_image[`SMI_BIT_ANA_CMP] = analog_supply_above_trip;
assign ctrl_image[`SMI_BIT_LOW_FLAG] = flag_next;
assign ctrl_image[`SMI_BIT_DTRIP_HI] = digital_trip_sel[1];
assign ctrl_image[`SMI_BIT_DTRIP_LO] = digital_trip_sel[0];
assign ctrl_image[`SMI_BIT_ATRIP_HI] = analog_trip_sel[1];
assign ctrl_image[`SMI_BIT_ATRIP_LO] = analog_trip_sel[0];
assign ctrl_image[`SMI_BIT_ENABLE] = monitor_enable;

always @(posedge clk_sys) begin
    if (rst) begin
        sfr_rdata <= ctrl_reset_image;
    end else begin
        sfr_rdata <= ctrl_image;
    end
end

endmodule

// [verif/smi_sup_monitor.sv]
// Port assertions for the supply monitor
`timescale 1ns/100ps
`include "smi_regs.vh"
module smi_sup_monitor #(
    parameter HOLDOFF_CYCLES = 20,
    parameter GLITCH_CYCLES = 4
) (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata,
    input wire digital_supply_above_trip,
    input wire analog_supply_above_trip,
    input wire secondary_irq_enable_priority,
    input wire monitor_enable,
    input wire [1:0] digital_trip_sel,
    input wire [1:0] analog_trip_sel,
    input wire [12:0] digital_trip_mv,
    input wire [12:0] analog_trip_mv,
    input wire supply_low_flag,
    input wire supply_low_irq
);
    wire any_lo = ~(digital_supply_above_trip & analog_supply_above_trip);
    reg [15:0] hi_cnt;
    // Saturates so long quiet runs never wrap into a false short count
    always @(posedge clk_sys) begin
        if (rst || any_lo)
            hi_cnt <= 16'h0;
        else if (hi_cnt != 16'hffff)
            hi_cnt <= hi_cnt + 16'h1;
    end
    function [12:0] mv(input [1:0] s);
        case (s)
            2'h0: mv = `SMI_TRIP_MV_463;
            2'h1: mv = `SMI_TRIP_MV_308;
            2'h2: mv = `SMI_TRIP_MV_293;
            default: mv = `SMI_TRIP_MV_263;
        endcase
    endfunction
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence dig_low_run;
        (monitor_enable && !digital_supply_above_trip) [*6];
    endsequence
    sequence ana_low_run;
        (monitor_enable && !analog_supply_above_trip) [*6];
    endsequence
    a_dig_trip_level: assert property (!$past(rst) |->
        digital_trip_mv == mv($past(digital_trip_sel)))
        else $error("digital trip level wrong");
    a_ana_trip_level: assert property (!$past(rst) |->
        analog_trip_mv == mv($past(analog_trip_sel)))
        else $error("analog trip level wrong");
    a_read_image: assert property (!$past(rst) |-> sfr_rdata ==
        {$past(digital_supply_above_trip), $past(analog_supply_above_trip),
        supply_low_flag, $past(digital_trip_sel), $past(analog_trip_sel),
        $past(monitor_enable)}) else $error("read image wrong");
    a_enable_write: assert property (sfr_wr && sfr_addr == 8'hdf |=>
        monitor_enable == $past(sfr_wdata[0])) else $error("enable not set");
    a_irq_gated: assert property (supply_low_irq ==
        (supply_low_flag && $past(secondary_irq_enable_priority)))
        else $error("interrupt gating wrong");
    a_low_sets_flag: assert property (dig_low_run or ana_low_run |=>
        supply_low_flag) else $error("flag not set on low supply");
    a_glitch_reject: assert property ($rose(supply_low_flag) &&
        !$past(sfr_wr) && $past(monitor_enable, 2) |->
        $past(any_lo, 2) && $past(any_lo, 3) && $past(any_lo, 4) &&
        $past(any_lo, 5)) else $error("flag set by short glitch");
    a_holdoff_clear: assert property ($fell(supply_low_flag) &&
        !$past(sfr_wr) |-> hi_cnt >= HOLDOFF_CYCLES)
        else $error("flag cleared before hold-off");
endmodule

// [verif/smi_cmp_model.sv]
// Behavioural model of one supply comparator
`timescale 1ns/100ps
module smi_cmp_model (
    input wire [12:0] trip_mv,
    input wire [12:0] supply_mv,
    output wire above_trip
);
    // High only while strictly above the selected threshold
    assign above_trip = supply_mv > trip_mv;
endmodule

// [verif/supply_monitor_interrupt_tb_top.sv]
// Self-checking bench for the supply monitor
`timescale 1ns/100ps
module supply_monitor_interrupt_tb_top;
    localparam HOLD = 20;
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg [7:0] sfr_addr = 8'h00;
    reg sfr_wr = 1'b0;
    reg [7:0] sfr_wdata = 8'h00;
    reg irq_en = 1'b0;
    reg [12:0] dmv = 13'h1388;
    reg [12:0] amv = 13'h1388;
    wire [7:0] sfr_rdata;
    wire dig_hi, ana_hi, en, flag, irq;
    wire [1:0] dsel, asel;
    wire [12:0] dtrip, atrip;
    integer miscompares = 0, n_checks = 0, cyc = 0, i, e, dv, av;
    integer trip_tab [0:3];
    always #5 clk_sys = ~clk_sys;
    smi_supply_monitor #(.HOLDOFF_CYCLES(HOLD), .GLITCH_CYCLES(4)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .digital_supply_above_trip(dig_hi), .analog_supply_above_trip(ana_hi),
        .secondary_irq_enable_priority(irq_en), .monitor_enable(en),
        .digital_trip_sel(dsel), .analog_trip_sel(asel),
        .digital_trip_mv(dtrip), .analog_trip_mv(atrip),
        .supply_low_flag(flag), .supply_low_irq(irq));
    smi_cmp_model u_dcmp (.trip_mv(dtrip), .supply_mv(dmv), .above_trip(dig_hi));
    smi_cmp_model u_acmp (.trip_mv(atrip), .supply_mv(amv), .above_trip(ana_hi));
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk_sys);
            #1;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            sfr_addr <= a;
            sfr_wdata <= d;
            sfr_wr <= 1'b1;
            @(posedge clk_sys);
            sfr_wr <= 1'b0;
        end
    endtask
    task sup(input integer d, input integer a);
        begin
            @(posedge clk_sys);
            dmv <= d[12:0];
            amv <= a[12:0];
        end
    endtask
    task chk(input string nm, input [12:0] exp, input [12:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch %0s exp %0h got %0h", nm, exp, got);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    initial begin
        i = $urandom(32'hb287);
        trip_tab[0] = 4630;
        trip_tab[1] = 3080;
        trip_tab[2] = 2930;
        trip_tab[3] = 2630;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        tick(0);
        chk("reset", 13'h0de, {5'h0, sfr_rdata});
        // Monitor off: comparators read live, flag must stay clear
        for (i = 0; i < 4; i = i + 1) begin
            dv = 2400 + $urandom % 2400;
            av = 2400 + $urandom % 2400;
            sup(dv, av);
            wr(8'hdf ^ (8'h01 << i), 8'hff);
            wr(8'hdf, {3'h0, i[1:0], 2'h3 - i[1:0], 1'b0});
            tick(3);
            chk("dtrip", trip_tab[i], dtrip);
            chk("atrip", trip_tab[3 - i], atrip);
            e = (dv > trip_tab[i]) * 128 + (av > trip_tab[3 - i]) * 64;
            e = e + i * 8 + (3 - i) * 2;
            chk("rdata", e[12:0], {5'h0, sfr_rdata});
        end
        $display("test trip select done");
        sup(5000, 5000);
        tick(6);
        wr(8'hdf, 8'h01);
        irq_en <= 1'b1;
        sup(2000, 5000);
        tick(2);
        sup(5000, 5000);
        tick(8);
        chk("glitch", 13'h0, {12'h0, flag});
        sup(2000, 5000);
        tick(8);
        chk("flag", 13'h1, {12'h0, flag});
        chk("irq", 13'h1, {12'h0, irq});
        chk("rdata", 13'h061, {5'h0, sfr_rdata});
        wr(8'hdf, 8'h01);
        tick(2);
        chk("clear", 13'h1, {12'h0, flag});
        @(posedge clk_sys);
        irq_en <= 1'b0;
        tick(2);
        chk("irq off", 13'h0, {12'h0, irq});
        $display("test fault done");
        sup(5000, 5000);
        tick(HOLD / 2);
        sup(5000, 2000);
        tick(8);
        sup(5000, 5000);
        tick(HOLD);
        chk("restart", 13'h1, {12'h0, flag});
        tick(10);
        chk("expiry", 13'h0, {12'h0, flag});
        wr(8'hdf, 8'h21);
        tick(1);
        chk("sw set", 13'h1, {12'h0, flag});
        wr(8'hdf, 8'h01);
        tick(1);
        chk("sw clr", 13'h0, {12'h0, flag});
        $display("test hold-off done");
        final_report;
    end
endmodule
bind smi_supply_monitor smi_sup_monitor #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES),
    .GLITCH_CYCLES(GLITCH_CYCLES)) u_mon (.clk_sys(clk_sys), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .digital_supply_above_trip(digital_supply_above_trip),
    .analog_supply_above_trip(analog_supply_above_trip),
    .secondary_irq_enable_priority(secondary_irq_enable_priority),
    .monitor_enable(monitor_enable), .digital_trip_sel(digital_trip_sel),
    .analog_trip_sel(analog_trip_sel), .digital_trip_mv(digital_trip_mv),
    .analog_trip_mv(analog_trip_mv), .supply_low_flag(supply_low_flag),
    .supply_low_irq(supply_low_irq));
